// >>> design/cmg_defines.svh
// Constants for the clock mode generator
`ifndef CMG_DEFINES_SVH
`define CMG_DEFINES_SVH
`define CMG_MODE_EXT_DIV2 3'b001
`define CMG_MODE_PLL_MUL2 3'b011
`define CMG_MODE_OSC_DIV2 3'b111
`define CMG_PLL_LOCK_PERIODS 1500
`define CMG_PLL_FACTOR 2
`define CMG_EDGE_TIMEOUT 16'd64
`endif

// >>> design/cmg_pkg.sv
// Types for the clock mode generator
package cmg_pkg;
    typedef enum logic [3:0] {
        CMG_ST_OFF = 4'b0001,
        CMG_ST_DIV = 4'b0010,
        CMG_ST_LOCK = 4'b0100,
        CMG_ST_RUN = 4'b1000
    } cmg_state_type;
endpackage : cmg_pkg

// >>> design/cmg_ref_if.sv
// Reference edge carrier between edge detector and generator
interface cmg_ref_if;
    logic rise;
    logic fall;
    logic level;
    modport src (output rise, output fall, output level);
    modport dst (input rise, input fall, input level);
endinterface : cmg_ref_if

// >>> design/cmg_edge_det.sv
// Edge detector on the sampled reference input
module cmg_edge_det (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic ref_i,
    cmg_ref_if.src edges
);
    logic prev_reg;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= ref_i;
        end
    end

    assign edges.rise = ref_i & ~prev_reg;
    assign edges.fall = ~ref_i & prev_reg;
    assign edges.level = prev_reg;
endmodule : cmg_edge_det

// >>> design/cmg_clock_mode_gen.sv
// Clock mode generator: mode decode, divide, multiply and lock phase
// Contract
// - Mode 0,0,1: external input halved, oscillator off.
// - Mode 0,1,1: PLL doubles the external input; factor two only.
// - Mode 1,1,1: oscillator on, crystal or external input halved.
// - With a crystal, machine clock is exactly half crystal frequency.
// - External divide: clock input halved, crystal drive pin unused.
// - PLL counts up to 1500 input periods unsynchronized before lock.
// - Divide modes fully static, no minimum input frequency.
// - PLL input stops only in deep idle; restart reapplies lock phase.
`include "cmg_defines.svh"
module cmg_clock_mode_gen
    import cmg_pkg::*;
#(
    parameter int LOCK_PERIODS = `CMG_PLL_LOCK_PERIODS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic clock_mode_select_a_i,
    input wire logic clock_mode_select_b_i,
    input wire logic clock_mode_select_c_i,
    input wire logic clock_input_pin_i,
    input wire logic deep_idle_state_i,
    output logic machine_clock_output_o,
    output logic osc_enable_o,
    output logic crystal_drive_pin_o,
    output logic crystal_drive_pin_oe_n_o,
    output logic pll_locked_o,
    output logic mode_reserved_o
);
    localparam int CW = 16;

    // Lock counter is CW bits wide
    if (LOCK_PERIODS < 1 || LOCK_PERIODS > 65535) begin : g_bad_lock
        $error("LOCK_PERIODS out of range");
    end

    cmg_ref_if edges ();
    cmg_edge_det u_edge (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .ref_i(clock_input_pin_i),
        .edges(edges)
    );

    wire logic [2:0] mode = {clock_mode_select_a_i, clock_mode_select_b_i,
                             clock_mode_select_c_i};
    wire logic is_ext = (mode == `CMG_MODE_EXT_DIV2);
    wire logic is_pll = (mode == `CMG_MODE_PLL_MUL2);
    wire logic is_osc = (mode == `CMG_MODE_OSC_DIV2);
    wire logic is_div = is_ext | is_osc;
    wire logic is_rsv = ~(is_div | is_pll);

    cmg_state_type state_reg, state_next;
    logic [CW-1:0] lock_cnt_reg, lock_cnt_next;
    logic [CW-1:0] quarter_reg, quarter_next;
    logic [CW-1:0] per_cnt_reg, per_cnt_next;
    logic [CW-1:0] qtr_cnt_reg;
    logic [1:0] ins_left_reg;
    logic div_reg, clk_reg, locked_reg, osc_reg, rsv_reg, oe_n_reg;

    // Divide-by-two toggles on each rising input edge, no timing dependence
    wire logic div_next = edges.rise ? ~div_reg : div_reg;
    // Input considered stopped when no rising edge for the timeout
    wire logic stalled = (per_cnt_reg >= `CMG_EDGE_TIMEOUT);
    wire logic restart = is_pll & stalled & deep_idle_state_i;
    wire logic [CW-1:0] per_len = per_cnt_reg + CW'(1);
    // Three toggles inserted at quarter points: two machine periods per input period
    wire logic qtr_hit = (qtr_cnt_reg == quarter_reg - CW'(1)) & (quarter_reg != '0)
                         & (ins_left_reg != 2'h0);
    wire logic pll_toggle = edges.rise | qtr_hit;
    wire logic [CW-1:0] qtr_cnt_next = pll_toggle ? '0 : qtr_cnt_reg + CW'(1);
    wire logic [1:0] ins_dec = ins_left_reg - 2'h1;
    wire logic [1:0] ins_left_next = edges.rise ? 2'h3 : (qtr_hit ? ins_dec : ins_left_reg);

    always_comb begin
        state_next = state_reg;
        lock_cnt_next = lock_cnt_reg;
        case (state_reg)
            CMG_ST_OFF: begin
                if (is_div) begin
                    state_next = CMG_ST_DIV;
                end else if (is_pll) begin
                    state_next = CMG_ST_LOCK;
                    lock_cnt_next = '0;
                end
            end
            CMG_ST_DIV: begin
                if (!is_div) begin
                    state_next = CMG_ST_OFF;
                end
            end
            CMG_ST_LOCK: begin
                if (!is_pll || restart) begin
                    state_next = CMG_ST_OFF;
                end else if (edges.rise) begin
                    if (lock_cnt_reg == CW'(LOCK_PERIODS - 1)) begin
                        state_next = CMG_ST_RUN;
                    end
                    lock_cnt_next = lock_cnt_reg + 1'b1;
                end
            end
            CMG_ST_RUN: begin
                if (!is_pll || restart) begin
                    state_next = CMG_ST_OFF;
                end
            end
            default: state_next = CMG_ST_OFF;
        endcase
    end

    // Period measure for the multiply: quarter period spaces the inserted edges
    always_comb begin
        per_cnt_next = per_cnt_reg;
        quarter_next = quarter_reg;
        if (edges.rise) begin
            per_cnt_next = '0;
            quarter_next = {2'h0, per_len[CW-1:2]};
        end else if (!stalled) begin
            per_cnt_next = per_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_reg <= CMG_ST_OFF;
            lock_cnt_reg <= '0;
            per_cnt_reg <= '0;
            quarter_reg <= '0;
            qtr_cnt_reg <= '0;
            ins_left_reg <= 2'h0;
            div_reg <= 1'b0;
            clk_reg <= 1'b0;
            locked_reg <= 1'b0;
            osc_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            rsv_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            lock_cnt_reg <= lock_cnt_next;
            per_cnt_reg <= per_cnt_next;
            quarter_reg <= quarter_next;
            qtr_cnt_reg <= qtr_cnt_next;
            ins_left_reg <= ins_left_next;
            // Divider phase follows the output so every input rise toggles it
            div_reg <= (state_reg == CMG_ST_DIV) ? div_next : 1'b0;
            locked_reg <= (state_next == CMG_ST_RUN);
            osc_reg <= is_osc;
            oe_n_reg <= ~is_osc;
            rsv_reg <= is_rsv;
            if (state_reg == CMG_ST_DIV) begin
                clk_reg <= div_next;
            end else if (state_reg == CMG_ST_RUN) begin
                // One machine period per input half period
                clk_reg <= pll_toggle ? ~clk_reg : clk_reg;
            end else begin
                clk_reg <= 1'b0;
            end
        end
    end

    assign machine_clock_output_o = clk_reg;
    assign osc_enable_o = osc_reg;
    assign crystal_drive_pin_o = 1'b0;
    // Drive pin released except in oscillator mode; leaves it open otherwise
    assign crystal_drive_pin_oe_n_o = oe_n_reg;
    assign pll_locked_o = locked_reg;
    assign mode_reserved_o = rsv_reg;

    // Assertions
    property p_rsv_no_clk;
        @(posedge clk_i) disable iff (!nrst_i)
        is_rsv |=> ##1 !machine_clock_output_o;
    endproperty
    a_rsv_no_clk: assert property (p_rsv_no_clk) else $error("clock in reserved mode");

    property p_osc_off_ext;
        @(posedge clk_i) disable iff (!nrst_i)
        is_ext |=> !osc_enable_o;
    endproperty
    a_osc_off_ext: assert property (p_osc_off_ext) else $error("oscillator on in ext");

    property p_osc_on;
        @(posedge clk_i) disable iff (!nrst_i)
        is_osc |=> osc_enable_o && !crystal_drive_pin_oe_n_o;
    endproperty
    a_osc_on: assert property (p_osc_on) else $error("oscillator off in osc mode");

    property p_ext_drive_off;
        @(posedge clk_i) disable iff (!nrst_i)
        is_ext |=> crystal_drive_pin_oe_n_o;
    endproperty
    a_ext_drive_off: assert property (p_ext_drive_off) else $error("drive pin used");

    property p_div_toggle;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == CMG_ST_DIV && is_div) ##0 edges.rise |=>
            machine_clock_output_o != $past(machine_clock_output_o);
    endproperty
    a_div_toggle: assert property (p_div_toggle) else $error("divider missed edge");

    property p_div_static;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == CMG_ST_DIV && is_div && !edges.rise) |=> $stable(machine_clock_output_o);
    endproperty
    a_div_static: assert property (p_div_static) else $error("divider moved alone");

    property p_lock_hold;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == CMG_ST_LOCK) |-> !pll_locked_o && !machine_clock_output_o;
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked too early");

    property p_lock_count;
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(pll_locked_o) |-> lock_cnt_reg == CW'(LOCK_PERIODS);
    endproperty
    a_lock_count: assert property (p_lock_count) else $error("lock count wrong");

    property p_restart;
        @(posedge clk_i) disable iff (!nrst_i)
        (state_reg == CMG_ST_RUN && restart) |=> ##1 !pll_locked_o;
    endproperty
    a_restart: assert property (p_restart) else $error("no relock on restart");

    property p_pll_mode;
        @(posedge clk_i) disable iff (!nrst_i)
        pll_locked_o |-> $past(is_pll);
    endproperty
    a_pll_mode: assert property (p_pll_mode) else $error("locked outside pll");

    c_lock: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(pll_locked_o));
    c_div: cover property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == CMG_ST_DIV && $rose(machine_clock_output_o));
    c_rsv: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(mode_reserved_o));
    c_restart: cover property (@(posedge clk_i) disable iff (!nrst_i)
        state_reg == CMG_ST_RUN && restart);
endmodule : cmg_clock_mode_gen

// >>> bench/cmg_ext_source.sv
// External reference source driving the clock input pin
module cmg_ext_source (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [15:0] half_i,
    output logic clock_input_pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_reg;
    initial begin
        cnt_reg = 16'h0;
        clock_input_pin_o = 1'b0;
    end
    // Stopped source stands low; crystal drive side never driven
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt_reg <= 16'h0;
            clock_input_pin_o <= 1'b0;
        end else if (cnt_reg >= half_i - 16'h1) begin
            cnt_reg <= 16'h0;
            clock_input_pin_o <= ~clock_input_pin_o;
        end else begin
            cnt_reg <= cnt_reg + 16'h1;
        end
    end
endmodule : cmg_ext_source

// >>> bench/testbench.sv
// Self-checking bench for the clock mode generator
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LOCK_N = 4;
    logic clk_i, nrst_i, sa, sb, sc, idle, run, ref_clk, mclk, osc, oe_n, lock, rsvd, xdrv;
    logic [15:0] half, p;
    int error_cnt = 0;
    int n_tests = 0;
    logic [2:0] codes [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h6};
    cmg_ext_source i_cmg_ext_source (.clk_i(clk_i), .run_i(run), .half_i(half),
        .clock_input_pin_o(ref_clk));
    cmg_clock_mode_gen #(.LOCK_PERIODS(LOCK_N)) i_cmg_clock_mode_gen (.clk_i(clk_i),
        .nrst_i(nrst_i), .clock_mode_select_a_i(sa), .clock_mode_select_b_i(sb),
        .clock_mode_select_c_i(sc), .clock_input_pin_i(ref_clk), .deep_idle_state_i(idle),
        .machine_clock_output_o(mclk), .osc_enable_o(osc), .crystal_drive_pin_o(xdrv),
        .crystal_drive_pin_oe_n_o(oe_n), .pll_locked_o(lock), .mode_reserved_o(rsvd));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic end_sim();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic set_mode(input logic [2:0] m, input logic [15:0] h);
        @(posedge clk_i);
        {sa, sb, sc} <= m;
        half <= h;
        run <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1;
    endtask : set_mode
    // Cycles from one output rise to the next, bounded
    task automatic period(output logic [15:0] len);
        logic prev;
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                prev = mclk;
                @(posedge clk_i);
                #1;
                n++;
            end while (!(prev === 1'b0 && mclk === 1'b1) && n < 1000);
        end
        len = n[15:0];
    endtask : period
    task automatic test_div();
        for (int h = 3; h < 50; h += 37) begin
            set_mode(3'h1, h[15:0]);
            check("osc_enable", {15'h0, osc}, 16'h0);
            check("xtal_oe_n", {15'h0, oe_n}, 16'h1);
            check("xtal_drive", {15'h0, xdrv}, 16'h0);
            period(p);
            check("div_period", p, 16'(4 * h));
        end
        set_mode(3'h7, 16'h5);
        check("osc_enable", {15'h0, osc}, 16'h1);
        check("xtal_oe_n", {15'h0, oe_n}, 16'h0);
        period(p);
        check("osc_period", p, 16'h14);
    endtask : test_div
    task automatic test_pll();
        set_mode(3'h3, 16'h8);
        check("lock_early", {15'h0, lock}, 16'h0);
        repeat (LOCK_N * 16 + 12) @(posedge clk_i);
        #1;
        check("lock_done", {15'h0, lock}, 16'h1);
        period(p);
        check("pll_period", p, 16'h8);
        @(posedge clk_i);
        idle <= 1'b1;
        run <= 1'b0;
        repeat (80) @(posedge clk_i);
        #1;
        check("lock_idle", {15'h0, lock}, 16'h0);
        @(posedge clk_i);
        idle <= 1'b0;
        run <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        check("relock_early", {15'h0, lock}, 16'h0);
        repeat (LOCK_N * 16 + 12) @(posedge clk_i);
        #1;
        check("relock_done", {15'h0, lock}, 16'h1);
    endtask : test_pll
    task automatic test_reserved();
        foreach (codes[i]) begin
            set_mode(codes[i], 16'h3);
            check("reserved_flag", {15'h0, rsvd}, 16'h1);
            check("reserved_clock", {15'h0, mclk}, 16'h0);
            repeat (7) @(posedge clk_i);
            #1;
            check("reserved_clock", {15'h0, mclk}, 16'h0);
        end
    endtask : test_reserved
    initial begin
        nrst_i = 1'b0;
        {sa, sb, sc} = 3'h0;
        idle = 1'b0;
        run = 1'b0;
        half = 16'h4;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        test_div();
        test_pll();
        test_reserved();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        end_sim();
    end
endmodule : testbench
